// *** hw/ildd_decoder.sv ***
// host i/o address decoder for the logical devices, with base registers
`timescale 1ns/100ps
module ildd_decoder (
  input  wire logic                      clock,              // 100 mhz bus clock
  input  wire logic                      rst_n,              // async reset, active low
  input  wire logic [15:0]               io_addr,            // host address pins
  input  wire logic                      io_rd_n,            // host i/o read strobe pin
  input  wire logic                      io_wr_n,            // host i/o write strobe pin
  input  wire logic                      io_aen,             // dma address enable pin, high blocks decode
  input  wire logic                      cfg_wr,             // configuration write pulse
  input  wire logic                      cfg_rd,             // configuration read pulse
  input  wire logic [7:0]                cfg_ldn,            // selected logical device number
  input  wire logic [7:0]                cfg_index,          // configuration register index
  input  wire logic [7:0]                cfg_wdata,          // configuration write data
  output logic      [7:0]                cfg_rdata,          // configuration read data
  output logic      [ildd_pkg::NSEL-1:0] dev_sel,            // one-hot logical device select
  output logic                           epp_sel,            // enhanced parallel address/data access
  output logic                           ecp_ext_sel,        // extended parallel register access
  output logic      [2:0]                reg_offset,         // register offset inside the window
  output logic                           io_read,            // decoded access is a read
  output logic                           io_write,           // decoded access is a write
  output logic                           zero_wait_state_n,  // open-drain value, low when driven
  output logic                           zero_wait_state_oe  // high while driving the line low
);
  typedef struct packed {
    logic [15:0]                           a1;
    logic [15:0]                           a2;
    logic                                  rd1_n;
    logic                                  rd2_n;
    logic                                  wr1_n;
    logic                                  wr2_n;
    logic                                  aen1;
    logic                                  aen2;
    logic [ildd_pkg::NBASE-1:0][15:0]      base;
    logic [ildd_pkg::NSEL-1:0]             sel;
    logic                                  epp;
    logic                                  ecp;
    logic [2:0]                            ofs;
    logic                                  rd;
    logic                                  wr;
    logic                                  nows;
    logic [7:0]                            rdata;
  } ildd_dec_state_t;

  localparam ildd_dec_state_t ST_RST = '{
    a1: 16'h0000, a2: 16'h0000, rd1_n: 1'b1, rd2_n: 1'b1, wr1_n: 1'b1, wr2_n: 1'b1,
    aen1: 1'b1, aen2: 1'b1, base: {ildd_pkg::NBASE{ildd_pkg::BASE_RST}},
    sel: '0, epp: 1'b0, ecp: 1'b0, ofs: 3'h0, rd: 1'b0, wr: 1'b0, nows: 1'b0, rdata: 8'h00};

  ildd_dec_state_t q;
  ildd_dec_state_t d;

  // base slot reached by a configuration access, or -1 when nothing is mapped
  function automatic int base_slot(input logic [7:0] ldn, input logic [7:0] idx);
    int s;
    s = -1;
    if (idx == ildd_pkg::IDX_BASE_HI || idx == ildd_pkg::IDX_BASE_LO)
    begin
      unique case (ldn)
        ildd_pkg::LDN_FLOPPY: s = ildd_pkg::B_FLOPPY;
        ildd_pkg::LDN_PAR:  s = ildd_pkg::B_PAR;
        ildd_pkg::LDN_SER1: s = ildd_pkg::B_SER1;
        ildd_pkg::LDN_SER2: s = ildd_pkg::B_SER2;
        default:            s = -1;
      endcase
    end
    else if ((idx == ildd_pkg::IDX_IR_HI || idx == ildd_pkg::IDX_IR_LO) && ldn == ildd_pkg::LDN_SER2)
      s = ildd_pkg::B_IR;
    return s;
  endfunction

  // six relocatable windows; the extended parallel one looks at address minus 0x400
  ildd_win_if win [ildd_pkg::NWIN] ();
  logic [ildd_pkg::NWIN-1:0] w_hit;
  logic [ildd_pkg::NWIN-1:0] w_ok;

  for (genvar i = 0; i < ildd_pkg::NWIN; i++)
  begin : g_win
    localparam bit IS_EXT = (i == ildd_pkg::W_PAR_EXT);
    localparam bit IS_PAR = (i == ildd_pkg::B_PAR) || IS_EXT;
    assign win[i].addr = IS_EXT ? 16'(q.a2 - ildd_pkg::PAR_EXT_OFS) : q.a2;
    assign win[i].base = q.base[IS_EXT ? ildd_pkg::B_PAR : i];
    assign w_hit[i]    = win[i].hit;
    assign w_ok[i]     = win[i].base_ok;
    ildd_window #(
      .ALIGN_BITS (IS_PAR ? 2 : 3),
      .MAX_BASE   (IS_PAR ? ildd_pkg::BASE_MAX4 : ildd_pkg::BASE_MAX8)
    ) u_win (
      .w (win[i])
    );
  end

  logic cyc;
  logic par8;
  assign cyc  = !q.aen2 && (!q.rd2_n || !q.wr2_n);
  assign par8 = w_ok[ildd_pkg::B_PAR] && !q.base[ildd_pkg::B_PAR][2];

  always_comb
  begin
    int slot;
    slot = base_slot(cfg_ldn, cfg_index);
    d = q;
    // pins pass two flops before anything decodes them
    d.a1    = io_addr;
    d.a2    = q.a1;
    d.rd1_n = io_rd_n;
    d.rd2_n = q.rd1_n;
    d.wr1_n = io_wr_n;
    d.wr2_n = q.wr1_n;
    d.aen1  = io_aen;
    d.aen2  = q.aen1;

    if (cfg_wr && slot >= 0)
    begin
      if (cfg_index[0])
        d.base[slot][7:0] = cfg_wdata;
      else
        d.base[slot][15:8] = cfg_wdata;
    end
    d.rdata = q.rdata;
    if (cfg_rd)
      d.rdata = (slot < 0) ? 8'h00 : (cfg_index[0] ? q.base[slot][7:0] : q.base[slot][15:8]);

    d.sel  = '0;
    d.epp  = 1'b0;
    d.ecp  = 1'b0;
    d.ofs  = q.a2[2:0];
    d.nows = 1'b0;
    if (cyc)
    begin
      // fixed devices compare the full sixteen bits
      if (q.a2 == ildd_pkg::KBD_DATA || q.a2 == ildd_pkg::KBD_CMD)
        d.sel[ildd_pkg::S_KBD] = 1'b1;
      else if (q.a2 == ildd_pkg::RTC_IDX0 || q.a2 == ildd_pkg::RTC_DATA
               || q.a2 == ildd_pkg::RTC_IDX1)
        d.sel[ildd_pkg::S_RTC] = 1'b1;
      // overlapping windows resolve by fixed priority so the select stays one-hot
      else if (w_hit[ildd_pkg::B_FLOPPY])
        d.sel[ildd_pkg::S_FLOPPY] = 1'b1;
      else if (w_hit[ildd_pkg::B_PAR] && q.a2[1:0] != 2'h3)
        d.sel[ildd_pkg::S_PAR] = 1'b1;
      else if (par8 && q.a2[15:3] == q.base[ildd_pkg::B_PAR][15:3] && q.a2[2:0] >= ildd_pkg::EPP_FIRST)
      begin
        d.sel[ildd_pkg::S_PAR] = 1'b1;
        d.epp                  = 1'b1;
      end
      else if (par8 && w_hit[ildd_pkg::W_PAR_EXT] && q.a2[1:0] <= ildd_pkg::PAR_EXT_LAST)
      begin
        d.sel[ildd_pkg::S_PAR] = 1'b1;
        d.ecp                  = 1'b1;
      end
      else if (w_hit[ildd_pkg::B_SER1])
        d.sel[ildd_pkg::S_SER1] = 1'b1;
      else if (w_hit[ildd_pkg::B_SER2])
        d.sel[ildd_pkg::S_SER2] = 1'b1;
      else if (w_hit[ildd_pkg::B_IR])
        d.sel[ildd_pkg::S_IR] = 1'b1;
      // wait states only for enhanced data/address and clock data
      d.nows = (|d.sel) && !d.epp && (q.a2 != ildd_pkg::RTC_DATA);
    end
    d.rd = cyc && !q.rd2_n && (|d.sel);
    d.wr = cyc && !q.wr2_n && (|d.sel);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= ST_RST;
    else
      q <= d;
  end

  assign cfg_rdata          = q.rdata;
  assign dev_sel            = q.sel;
  assign epp_sel            = q.epp;
  assign ecp_ext_sel        = q.ecp;
  assign reg_offset         = q.ofs;
  assign io_read            = q.rd;
  assign io_write           = q.wr;
  assign zero_wait_state_n  = 1'b0;
  assign zero_wait_state_oe = q.nows;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_full_addr;
    cyc && q.a2 == (ildd_pkg::KBD_DATA | 16'h1000) |=> !dev_sel[ildd_pkg::S_KBD];
  endproperty
  a_full_addr: assert property (p_full_addr) else $error("truncated address hit keyboard");

  property p_floppy_win;
    cyc && w_ok[ildd_pkg::B_FLOPPY] && q.a2[15:3] == q.base[ildd_pkg::B_FLOPPY][15:3]
      |=> dev_sel[ildd_pkg::S_FLOPPY] && reg_offset == $past(q.a2[2:0]) && zero_wait_state_oe;
  endproperty
  a_floppy_win: assert property (p_floppy_win) else $error("floppy window miss");

  property p_par4_no_epp;
    q.base[ildd_pkg::B_PAR][2] |=> !epp_sel && !ecp_ext_sel;
  endproperty
  a_par4_no_epp: assert property (p_par4_no_epp) else $error("enhanced access on four-aligned base");

  property p_ecp_ext;
    cyc && par8 && q.a2 == 16'(q.base[ildd_pkg::B_PAR] + ildd_pkg::PAR_EXT_OFS + 16'h0002)
      |=> ecp_ext_sel && reg_offset[1:0] == 2'h2 && zero_wait_state_oe;
  endproperty
  a_ecp_ext: assert property (p_ecp_ext) else $error("extended control not decoded");

  property p_ir_master;
    cyc && w_ok[ildd_pkg::B_IR] && !(|w_hit[ildd_pkg::B_SER2:0]) && !par8
      && q.a2 == (q.base[ildd_pkg::B_IR] | 16'(ildd_pkg::IR_MASTER))
      |=> dev_sel[ildd_pkg::S_IR] && reg_offset == ildd_pkg::IR_MASTER;
  endproperty
  a_ir_master: assert property (p_ir_master) else $error("infrared master control missed");

  property p_rtc_data;
    cyc && q.a2 == ildd_pkg::RTC_DATA |=> dev_sel[ildd_pkg::S_RTC] && !zero_wait_state_oe;
  endproperty
  a_rtc_data: assert property (p_rtc_data) else $error("clock data decode or wait wrong");

  property p_kbd_cmd;
    cyc && q.a2 == ildd_pkg::KBD_CMD |=> dev_sel[ildd_pkg::S_KBD] ##1 !dev_sel[ildd_pkg::S_KBD] || $past(cyc);
  endproperty
  a_kbd_cmd: assert property (p_kbd_cmd) else $error("keyboard command not decoded");

  property p_epp_wait;
    epp_sel |-> !zero_wait_state_oe && dev_sel[ildd_pkg::S_PAR];
  endproperty
  a_epp_wait: assert property (p_epp_wait) else $error("zero wait on enhanced access");

  property p_zws_other;
    (|dev_sel) && !epp_sel && $past(q.a2) != ildd_pkg::RTC_DATA |-> zero_wait_state_oe;
  endproperty
  a_zws_other: assert property (p_zws_other) else $error("zero wait missing");

  property p_base_hi;
    cfg_wr && cfg_ldn == ildd_pkg::LDN_FLOPPY && cfg_index == ildd_pkg::IDX_BASE_HI
      |=> q.base[ildd_pkg::B_FLOPPY][15:8] == $past(cfg_wdata);
  endproperty
  a_base_hi: assert property (p_base_hi) else $error("base high not stored");

  property p_bad_base;
    !w_ok[ildd_pkg::B_SER1] |=> !dev_sel[ildd_pkg::S_SER1];
  endproperty
  a_bad_base: assert property (p_bad_base) else $error("out-of-range serial base decoded");

  property p_onehot;
    $onehot0(dev_sel) && (!zero_wait_state_oe || (|dev_sel));
  endproperty
  a_onehot: assert property (p_onehot) else $error("select not one-hot");

  c_epp:  cover property (epp_sel && io_write);
  c_ecp:  cover property (ecp_ext_sel && io_read);
  c_ir:   cover property (dev_sel[ildd_pkg::S_IR]);
  c_rtc:  cover property (dev_sel[ildd_pkg::S_RTC] ##1 dev_sel[ildd_pkg::S_RTC]);
endmodule // ildd_decoder

// *** include/ildd_pkg.sv ***
// constants shared by the logical device address decoder
package ildd_pkg;
  // logical device numbers used on the configuration port
  localparam logic [7:0]  LDN_FLOPPY    = 8'h00;
  localparam logic [7:0]  LDN_PAR       = 8'h03;
  localparam logic [7:0]  LDN_SER1      = 8'h04;
  localparam logic [7:0]  LDN_SER2      = 8'h05;
  // configuration indices of the base registers
  localparam logic [7:0]  IDX_BASE_HI   = 8'h60;
  localparam logic [7:0]  IDX_BASE_LO   = 8'h61;
  localparam logic [7:0]  IDX_IR_HI     = 8'h62;
  localparam logic [7:0]  IDX_IR_LO     = 8'h63;
  // permitted base range, and the base loaded at reset
  localparam logic [15:0] BASE_MIN      = 16'h0100;
  localparam logic [15:0] BASE_MAX8     = 16'h0ff8;
  localparam logic [15:0] BASE_MAX4     = 16'h0ffc;
  localparam logic [15:0] BASE_RST      = 16'h0000;
  // extended parallel registers sit this far above the base
  localparam logic [15:0] PAR_EXT_OFS   = 16'h0400;
  localparam logic [1:0]  PAR_EXT_LAST  = 2'h2;
  localparam logic [2:0]  EPP_FIRST     = 3'h3;
  localparam logic [2:0]  IR_MASTER     = 3'h7;
  // fixed addresses
  localparam logic [15:0] KBD_DATA      = 16'h0060;
  localparam logic [15:0] KBD_CMD       = 16'h0064;
  localparam logic [15:0] RTC_IDX0      = 16'h0070;
  localparam logic [15:0] RTC_DATA      = 16'h0071;
  localparam logic [15:0] RTC_IDX1      = 16'h0074;
  // base register slots
  localparam int          B_FLOPPY      = 0;
  localparam int          B_PAR         = 1;
  localparam int          B_SER1        = 2;
  localparam int          B_SER2        = 3;
  localparam int          B_IR          = 4;
  localparam int          NBASE         = 5;
  // address windows; the extended parallel window reuses the parallel base
  localparam int          W_PAR_EXT     = 5;
  localparam int          NWIN          = 6;
  // select vector bit positions
  localparam int          S_FLOPPY      = 0;
  localparam int          S_PAR         = 1;
  localparam int          S_SER1        = 2;
  localparam int          S_SER2        = 3;
  localparam int          S_IR          = 4;
  localparam int          S_RTC         = 5;
  localparam int          S_KBD         = 6;
  localparam int          NSEL          = 7;
endpackage

// *** include/ildd_win_if.sv ***
// carrier between the decoder and one relocatable address window matcher
`timescale 1ns/100ps
interface ildd_win_if;
  logic [15:0] addr;
  logic [15:0] base;
  logic        hit;
  logic        base_ok;
  modport requester (output addr, output base, input hit, input base_ok);
  modport matcher   (input addr, input base, output hit, output base_ok);
endinterface

// *** hw/ildd_window.sv ***
// full-width match of one host address against one relocatable base
`timescale 1ns/100ps
module ildd_window #(
  parameter int          ALIGN_BITS = 3,
  parameter logic [15:0] MAX_BASE   = 16'h0ff8
) (
  ildd_win_if.matcher w   // address and base in, hit and range flag out
);
  if (ALIGN_BITS < 2 || ALIGN_BITS > 3)
  begin : g_bad_align
    $error("ildd_window: ALIGN_BITS must be 2 or 3");
  end

  // base must be aligned and inside the permitted range, else the device is deaf
  assign w.base_ok = (w.base >= ildd_pkg::BASE_MIN) && (w.base <= MAX_BASE)
                     && (w.base[ALIGN_BITS-1:0] == '0);
  // every address bit above the window is compared, none truncated
  assign w.hit     = w.base_ok && (w.addr[15:ALIGN_BITS] == w.base[15:ALIGN_BITS]);
endmodule // ildd_window

// *** tb/ildd_host_model.sv ***
// isa host model that issues i/o read and write cycles to the decoder
`timescale 1ns/100ps
module ildd_host_model (
  input  wire logic        clock,    // bus clock
  output logic      [15:0] io_addr,  // host address pins
  output logic             io_rd_n,  // read strobe, active low
  output logic             io_wr_n,  // write strobe, active low
  output logic             io_aen    // dma address enable
);
  initial
  begin
    io_addr = 16'hffff;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_aen  = 1'b0;
  end
  // address and strobe stay put until stop, so the synchroniser always sees a stable cycle
  task automatic start(input logic [15:0] a, input logic wr, input logic aen);
    @(negedge clock);
    io_addr = a;
    io_aen  = aen;
    io_rd_n = wr;
    io_wr_n = ~wr;
  endtask
  // a released bus is inverted rather than held, so a stale address cannot fake a match
  task automatic stop();
    @(negedge clock);
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    io_aen  = 1'b0;
    io_addr = ~io_addr;
  endtask
endmodule // ildd_host_model

// *** tb/tb_isa_logical_device_decoder.sv ***
// self-checking bench for the logical device address decoder
`timescale 1ns/100ps
module tb_isa_logical_device_decoder;
  localparam logic [9:0]     ALL = 10'h3ff;
  logic                      clock;
  logic                      rst_n;
  logic [15:0]               io_addr;
  logic                      io_rd_n;
  logic                      io_wr_n;
  logic                      io_aen;
  logic                      cfg_wr;
  logic                      cfg_rd;
  logic [7:0]                cfg_ldn;
  logic [7:0]                cfg_index;
  logic [7:0]                cfg_wdata;
  logic [7:0]                cfg_rdata;
  logic [ildd_pkg::NSEL-1:0] dev_sel;
  logic                      epp_sel;
  logic                      ecp_ext_sel;
  logic [2:0]                reg_offset;
  logic                      io_read;
  logic                      io_write;
  logic                      zero_wait_state_n;
  logic                      zero_wait_state_oe;
  logic                      zws_line;
  logic [14:0]               got_v;
  int                        n_errors;
  int                        total_checks;

  // open-drain line: released means high
  assign zws_line = zero_wait_state_oe ? zero_wait_state_n : 1'b1;
  assign got_v = {dev_sel, epp_sel, ecp_ext_sel, ~zws_line, io_read, io_write, reg_offset};

  always #5 clock = ~clock;

  ildd_host_model i_host (.clock(clock), .io_addr(io_addr), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_aen(io_aen));

  ildd_decoder i_dut (.clock(clock), .rst_n(rst_n), .io_addr(io_addr), .io_rd_n(io_rd_n), .io_wr_n(io_wr_n),
    .io_aen(io_aen), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_ldn(cfg_ldn), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .dev_sel(dev_sel), .epp_sel(epp_sel),
    .ecp_ext_sel(ecp_ext_sel), .reg_offset(reg_offset), .io_read(io_read), .io_write(io_write),
    .zero_wait_state_n(zero_wait_state_n), .zero_wait_state_oe(zero_wait_state_oe));

  task automatic close_out();
    if (n_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input logic [14:0] m);
    total_checks++;
    if ((got & m) !== (exp & m))
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask

  function automatic logic [9:0] dv(input int s, input logic zw);
    dv = 10'h000;
    dv[3 + s] = 1'b1;
    dv[0] = zw;
  endfunction

  // e is {dev_sel, enhanced, extended, zero wait}; m hides selects the design may settle either way
  task automatic acc(input logic [15:0] a, input logic wr, input logic aen, input logic [9:0] e,
                     input logic [9:0] m);
    logic hit;
    hit = |e;
    i_host.start(a, wr, aen);
    repeat (4) @(negedge clock);
    chk(got_v, {e, ~wr & hit, wr & hit, a[2:0]}, {m, 2'h3, {3{hit}}});
    i_host.stop();
    repeat (4) @(negedge clock);
    chk(got_v, 15'h0000, 15'h7ff8);
  endtask

  task automatic cfg_op(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] d, input logic rd);
    @(negedge clock);
    cfg_ldn = ldn;
    cfg_index = idx;
    cfg_wdata = d;
    cfg_wr = ~rd;
    cfg_rd = rd;
    @(negedge clock);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
  endtask

  task automatic set_base(input logic [7:0] ldn, input logic [7:0] hi, input logic [15:0] b);
    cfg_op(ldn, hi, b[15:8], 1'b0);
    cfg_op(ldn, hi + 8'h01, b[7:0], 1'b0);
  endtask

  task automatic rd_base(input logic [7:0] ldn, input logic [7:0] idx, input logic [7:0] exp);
    cfg_op(ldn, idx, 8'h00, 1'b1);
    chk({7'h00, cfg_rdata}, {7'h00, exp}, 15'h00ff);
  endtask

  task automatic t_reset_silent();
    rd_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_LO, 8'h00);
    rd_base(8'h01, ildd_pkg::IDX_BASE_HI, 8'h00);
    acc(16'h0000, 1'b0, 1'b0, 10'h000, ALL);
  endtask

  task automatic t_fixed();
    acc(ildd_pkg::KBD_DATA, 1'b0, 1'b0, dv(ildd_pkg::S_KBD, 1'b1), ALL);
    acc(ildd_pkg::KBD_CMD, 1'b1, 1'b0, dv(ildd_pkg::S_KBD, 1'b1), ALL);
    acc(ildd_pkg::RTC_IDX0, 1'b1, 1'b0, dv(ildd_pkg::S_RTC, 1'b1), ALL);
    acc(ildd_pkg::RTC_IDX1, 1'b0, 1'b0, dv(ildd_pkg::S_RTC, 1'b1), ALL);
    acc(ildd_pkg::RTC_DATA, 1'b0, 1'b0, dv(ildd_pkg::S_RTC, 1'b0), ALL);
    acc(16'h0072, 1'b0, 1'b0, 10'h000, ALL);
    acc(16'h1060, 1'b0, 1'b0, 10'h000, ALL);
    acc(ildd_pkg::KBD_DATA, 1'b0, 1'b1, 10'h000, ALL);
  endtask

  task automatic t_floppy();
    set_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_HI, 16'h03f0);
    rd_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_HI, 8'h03);
    rd_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_LO, 8'hf0);
    acc(16'h03f7, 1'b1, 1'b0, dv(ildd_pkg::S_FLOPPY, 1'b1), ALL);
    acc(16'h13f0, 1'b0, 1'b0, 10'h000, ALL);
    acc(16'h03f8, 1'b0, 1'b0, 10'h000, ALL);
    set_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_HI, ildd_pkg::BASE_MAX8);
    acc(16'h0ffd, 1'b0, 1'b0, dv(ildd_pkg::S_FLOPPY, 1'b1), ALL);
    set_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_HI, 16'h00f8);
    acc(16'h00f8, 1'b0, 1'b0, 10'h000, ALL);
    set_base(ildd_pkg::LDN_FLOPPY, ildd_pkg::IDX_BASE_HI, 16'h03f4);
    acc(16'h03f4, 1'b0, 1'b0, 10'h000, ALL);
  endtask

  task automatic t_parallel();
    set_base(ildd_pkg::LDN_PAR, ildd_pkg::IDX_BASE_HI, 16'h0378);
    acc(16'h0378, 1'b1, 1'b0, dv(ildd_pkg::S_PAR, 1'b1), ALL);
    acc(16'h037b, 1'b0, 1'b0, dv(ildd_pkg::S_PAR, 1'b0) | 10'h004, ALL);
    acc(16'h037f, 1'b1, 1'b0, dv(ildd_pkg::S_PAR, 1'b0) | 10'h004, ALL);
    acc(16'h0778, 1'b0, 1'b0, dv(ildd_pkg::S_PAR, 1'b1) | 10'h002, ALL);
    acc(16'h077a, 1'b1, 1'b0, dv(ildd_pkg::S_PAR, 1'b1) | 10'h002, ALL);
    acc(16'h077b, 1'b0, 1'b0, 10'h000, ALL);
    set_base(ildd_pkg::LDN_PAR, ildd_pkg::IDX_BASE_HI, 16'h037c);
    acc(16'h037e, 1'b0, 1'b0, dv(ildd_pkg::S_PAR, 1'b1), ALL);
    acc(16'h037f, 1'b0, 1'b0, 10'h000, ALL);
    acc(16'h077c, 1'b0, 1'b0, 10'h000, ALL);
    set_base(ildd_pkg::LDN_PAR, ildd_pkg::IDX_BASE_HI, ildd_pkg::BASE_MAX4);
    acc(16'h0ffc, 1'b1, 1'b0, dv(ildd_pkg::S_PAR, 1'b1), ALL);
  endtask

  task automatic t_serial();
    set_base(ildd_pkg::LDN_SER1, ildd_pkg::IDX_BASE_HI, 16'h02f8);
    acc(16'h02fa, 1'b0, 1'b0, dv(ildd_pkg::S_SER1, 1'b1), ALL);
    set_base(ildd_pkg::LDN_SER2, ildd_pkg::IDX_BASE_HI, 16'h03e8);
    set_base(ildd_pkg::LDN_SER2, ildd_pkg::IDX_IR_HI, 16'h0280);
    rd_base(ildd_pkg::LDN_SER2, ildd_pkg::IDX_IR_LO, 8'h80);
    acc(16'h03ef, 1'b1, 1'b0, dv(ildd_pkg::S_SER2, 1'b1), ALL);
    acc(16'h0286, 1'b0, 1'b0, dv(ildd_pkg::S_IR, 1'b1), ALL);
    acc(16'h0287, 1'b1, 1'b0, dv(ildd_pkg::S_IR, 1'b1), ALL);
  endtask

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_ldn = 8'h00;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_reset_silent();
    t_fixed();
    t_floppy();
    t_parallel();
    t_serial();
    close_out();
  end

  // the whole run needs well under ten thousand cycles
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule // tb_isa_logical_device_decoder
